/* rtc_map.svh */
// Register offsets, field positions, reset values and timing counts of the clock block.
// What this block does
// - Seconds, minutes, hours and days advance from the incoming one-per-second tick.
// - With alarm enabled, an interrupt rises when running time reaches the alarm values.
// - A sampling timer makes fixed-frequency events independent of the alarm.
// - Periodic events occur every second, minute, hour and day.
// - Seconds are a six-bit counter in the seconds register.
// - Six-bit minutes and five-bit hours share the hours-and-minutes register.
// - Days are a sixteen-bit counter in the days register.
// - Three alarm registers mirror the counters; full equality raises the alarm event.
// - A stopwatch counts down in minute steps and flags on a minute boundary.
// - Time registers read and write anytime; a write replaces the running time at once.
// - Power-on reset zeroes reserved bits; time fields take no promised value.
// - Hours sit in bits 12 to 8; software writes only 0 to 23.
// - Minutes sit in bits 5 to 0; software writes only 0 to 59.
// - Seconds sit in bits 5 to 0; software writes only 0 to 59.
// - Reserved bits 31 to 13 and 7 to 6 read as zero.
// - Alarm hours sit in bits 12 to 8, range 0 to 23, as the counter.
// - Alarm minutes sit in bits 5 to 0, range 0 to 59.
// - Alarm registers read and write at any time without waiting.
// - Ten registers plus two oscillator count words, three unmapped words between.
// - Control bit 7 enables the clock; the soft reset leaves it unchanged.
// - Status bits set on events regardless of enables; writing one clears them.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define RTC_OFS_TIME_HM    12'h3C0
`define RTC_OFS_TIME_SEC   12'h3C4
`define RTC_OFS_ALM_HM     12'h3C8
`define RTC_OFS_ALM_SEC    12'h3CC
`define RTC_OFS_CTRL       12'h3D0
`define RTC_OFS_STATUS     12'h3D4
`define RTC_OFS_IRQ_EN     12'h3D8
`define RTC_OFS_STOPWATCH  12'h3DC
`define RTC_OFS_DAYS       12'h3E0
`define RTC_OFS_ALM_DAY    12'h3E4
`define RTC_OFS_OSC_UPPER  12'h3F4
`define RTC_OFS_OSC_LOWER  12'h3F8

`define RTC_HOURS_MSB      12
`define RTC_HOURS_LSB      8
`define RTC_MIN_MSB        5
`define RTC_SEC_MSB        5
`define RTC_CTRL_EN_BIT    7
`define RTC_CTRL_SRST_BIT  0

`define RTC_SEC_LAST       6'h3B
`define RTC_MIN_LAST       6'h3B
`define RTC_HOUR_LAST      5'h17
`define RTC_STOPWATCH_OFF  6'h3F
`define RTC_EN_RESET       1'b1

`define RTC_NUM_EVENTS     10
`define RTC_EV_STOPWATCH   0
`define RTC_EV_MINUTE      1
`define RTC_EV_ALARM       2
`define RTC_EV_DAY         3
`define RTC_EV_SECOND      4
`define RTC_EV_HOUR        5
`define RTC_EV_SAMPLE0     6

`define RTC_RESP_OKAY      2'h0
`define RTC_RESP_SLVERR    2'h2

`define RTC_CLK_HZ         50000000
`define RTC_SAMPLE_HZ      64
`define RTC_SAMPLE_CYCLES  (`RTC_CLK_HZ / `RTC_SAMPLE_HZ)

`endif

/* rtc_pkg.sv */
// Types shared by the clock block: bus channel bundles.
package rtc_pkg;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } axiReq_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axiRsp_t;

endpackage : rtc_pkg

/* rtc_time_of_day_alarm.sv */
// Time-of-day clock with alarm, stopwatch, periodic events and a register slave.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"

module rtc_time_of_day_alarm #(
    parameter int unsigned SAMPLE_DIV = `RTC_SAMPLE_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire rtc_pkg::axiReq_t bus,
    output wire rtc_pkg::axiRsp_t rsp,
    input  wire logic             tick1Hz,
    output logic                  irq
);
    import rtc_pkg::*;

    // ========================================================================
    // State
    // ========================================================================
    logic [4:0]  hours;
    logic [5:0]  minutes;
    logic [5:0]  seconds;
    logic [15:0] days;
    logic [4:0]  almHours;
    logic [5:0]  almMinutes;
    logic [5:0]  almSeconds;
    logic [15:0] almDays;
    logic        clockEnable;
    logic [`RTC_NUM_EVENTS-1:0] status;
    logic [`RTC_NUM_EVENTS-1:0] irqEnable;
    logic [5:0]  stopwatch;
    logic [31:0] oscUpper;
    logic [31:0] oscLower;
    logic [31:0] divCnt;
    logic [2:0]  sampCnt;
    logic        matchPrev;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;

    // Merges a write into a word, lane by lane.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ========================================================================
    // Write decode
    // ========================================================================
    // Address and data are taken together; one write is outstanding at most.
    // A lone address or data beat waits for its partner.
    wire wrTake = bus.awvalid && bus.wvalid && !bvalid;
    wire [11:0] wa = bus.awaddr;
    wire wrHm    = wrTake && (wa == `RTC_OFS_TIME_HM);
    wire wrSec   = wrTake && (wa == `RTC_OFS_TIME_SEC);
    wire wrAHm   = wrTake && (wa == `RTC_OFS_ALM_HM);
    wire wrASec  = wrTake && (wa == `RTC_OFS_ALM_SEC);
    wire wrCtrl  = wrTake && (wa == `RTC_OFS_CTRL);
    wire wrStat  = wrTake && (wa == `RTC_OFS_STATUS);
    wire wrIen   = wrTake && (wa == `RTC_OFS_IRQ_EN);
    wire wrSw    = wrTake && (wa == `RTC_OFS_STOPWATCH);
    wire wrDays  = wrTake && (wa == `RTC_OFS_DAYS);
    wire wrADay  = wrTake && (wa == `RTC_OFS_ALM_DAY);
    wire wrOscU  = wrTake && (wa == `RTC_OFS_OSC_UPPER);
    wire wrOscL  = wrTake && (wa == `RTC_OFS_OSC_LOWER);
    wire wrHit   = wrHm | wrSec | wrAHm | wrASec | wrCtrl | wrStat | wrIen
                 | wrSw | wrDays | wrADay | wrOscU | wrOscL;

    // Read views; reserved bits read as zero.
    wire [31:0] curHm   = {19'h00000, hours, 2'b00, minutes};
    wire [31:0] curSec  = {26'h0000000, seconds};
    wire [31:0] curAHm  = {19'h00000, almHours, 2'b00, almMinutes};
    wire [31:0] curASec = {26'h0000000, almSeconds};
    wire [31:0] curCtrl = {24'h000000, clockEnable, 7'h00};
    wire [31:0] curStat = {22'h000000, status};
    wire [31:0] curIen  = {22'h000000, irqEnable};
    wire [31:0] curSw   = {26'h0000000, stopwatch};
    wire [31:0] curDays = {16'h0000, days};
    wire [31:0] curADay = {16'h0000, almDays};

    // Unstrobed byte lanes keep their contents.
    wire [31:0] mHm   = merge(curHm, bus.wdata, bus.wstrb);
    wire [31:0] mSec  = merge(curSec, bus.wdata, bus.wstrb);
    wire [31:0] mAHm  = merge(curAHm, bus.wdata, bus.wstrb);
    wire [31:0] mASec = merge(curASec, bus.wdata, bus.wstrb);
    wire [31:0] mCtrl = merge(curCtrl, bus.wdata, bus.wstrb);
    wire [31:0] mIen  = merge(curIen, bus.wdata, bus.wstrb);
    wire [31:0] mSw   = merge(curSw, bus.wdata, bus.wstrb);
    wire [31:0] mDays = merge(curDays, bus.wdata, bus.wstrb);
    wire [31:0] mADay = merge(curADay, bus.wdata, bus.wstrb);
    wire [31:0] mOscU = merge(oscUpper, bus.wdata, bus.wstrb);
    wire [31:0] mOscL = merge(oscLower, bus.wdata, bus.wstrb);
    wire [31:0] clrMask = bus.wdata & {{8{bus.wstrb[3]}}, {8{bus.wstrb[2]}},
                                       {8{bus.wstrb[1]}}, {8{bus.wstrb[0]}}};

    // Soft reset acts in the cycle of its write.
    wire softReset = wrCtrl && mCtrl[`RTC_CTRL_SRST_BIT];

    // ========================================================================
    // Time counting
    // ========================================================================
    // A time write wins over a tick in one cycle.
    // Out-of-range writes wrap at the next carry.
    wire advance = tick1Hz && clockEnable;
    wire secWrap = (seconds >= `RTC_SEC_LAST);
    wire minWrap = (minutes >= `RTC_MIN_LAST);
    wire hrWrap  = (hours >= `RTC_HOUR_LAST);
    wire secEvt  = advance;
    wire minEvt  = advance && secWrap;
    wire hrEvt   = minEvt && minWrap;
    wire dayEvt  = hrEvt && hrWrap;

    // Next values, taken on a tick for seconds and on a carry otherwise.
    wire [5:0]  incSec  = secWrap ? 6'h00 : seconds + 6'h01;
    wire [5:0]  incMin  = minWrap ? 6'h00 : minutes + 6'h01;
    wire [4:0]  incHr   = hrWrap ? 5'h00 : hours + 5'h01;
    wire [15:0] incDays = days + 16'h0001;

    // ========================================================================
    // Sampling timer and stopwatch
    // ========================================================================
    // The sampling timer runs from the system clock, so it keeps time only
    // while that clock runs at its nominal rate.
    wire sampTick = clockEnable && (divCnt >= 32'(SAMPLE_DIV - 1));
    wire [3:0] sampEvt;
    // Bit 6 is the base rate; each next bit halves it.
    assign sampEvt[0] = sampTick;
    assign sampEvt[1] = sampTick && sampCnt[0];
    assign sampEvt[2] = sampTick && (&sampCnt[1:0]);
    assign sampEvt[3] = sampTick && (&sampCnt);

    // A stopwatch at zero flags on the next minute and parks at all ones.
    // Any other written value arms it.
    wire swRunning = (stopwatch != `RTC_STOPWATCH_OFF);
    wire swEvt     = minEvt && swRunning && (stopwatch == 6'h00);

    // ========================================================================
    // Alarm
    // ========================================================================
    // Registered values are compared, so the event trails a tick.
    // Only a rising match counts; a standing one flags once.
    wire match = (hours == almHours) && (minutes == almMinutes)
              && (seconds == almSeconds) && (days == almDays);
    wire alarmEvt = match && !matchPrev;

    // One status bit per event source.
    wire [`RTC_NUM_EVENTS-1:0] events;
    assign events[`RTC_EV_STOPWATCH] = swEvt;
    assign events[`RTC_EV_MINUTE]    = minEvt;
    assign events[`RTC_EV_ALARM]     = alarmEvt;
    assign events[`RTC_EV_DAY]       = dayEvt;
    assign events[`RTC_EV_SECOND]    = secEvt;
    assign events[`RTC_EV_HOUR]      = hrEvt;
    assign events[`RTC_EV_SAMPLE0 +: 4] = sampEvt;

    // Set wins over a clear written in the same cycle.
    wire [`RTC_NUM_EVENTS-1:0] clrBits = wrStat ? clrMask[`RTC_NUM_EVENTS-1:0]
                                                : '0;
    wire [`RTC_NUM_EVENTS-1:0] next_status = (status & ~clrBits) | events;

    assign irq = |(status & irqEnable);

    // ========================================================================
    // Counter registers
    // ========================================================================
    // Power-on leaves time fields at zero; software must still set the time.
    // Soft reset clears time too; the enable and the match history survive.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seconds <= 6'h00;
            minutes <= 6'h00;
            hours   <= 5'h00;
            days    <= 16'h0000;
        end else if (softReset) begin
            seconds <= 6'h00;
            minutes <= 6'h00;
            hours   <= 5'h00;
            days    <= 16'h0000;
        end else begin
            if (wrSec) begin
                seconds <= mSec[`RTC_SEC_MSB:0];
            end else if (advance) begin
                seconds <= incSec;
            end
            if (wrHm) begin
                minutes <= mHm[`RTC_MIN_MSB:0];
                hours   <= mHm[`RTC_HOURS_MSB:`RTC_HOURS_LSB];
            end else begin
                if (minEvt) begin
                    minutes <= incMin;
                end
                if (hrEvt) begin
                    hours <= incHr;
                end
            end
            if (wrDays) begin
                days <= mDays[15:0];
            end else if (dayEvt) begin
                days <= incDays;
            end
        end
    end

    // ========================================================================
    // Alarm, control and interrupt registers
    // Alarm and oscillator words are plain storage.
    // ========================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            almSeconds <= 6'h00;
            almMinutes <= 6'h00;
            almHours   <= 5'h00;
            almDays    <= 16'h0000;
            irqEnable  <= '0;
            status     <= '0;
            stopwatch  <= `RTC_STOPWATCH_OFF;
            oscUpper   <= 32'h00000000;
            oscLower   <= 32'h00000000;
        end else if (softReset) begin
            almSeconds <= 6'h00;
            almMinutes <= 6'h00;
            almHours   <= 5'h00;
            almDays    <= 16'h0000;
            irqEnable  <= '0;
            status     <= '0;
            stopwatch  <= `RTC_STOPWATCH_OFF;
            oscUpper   <= 32'h00000000;
            oscLower   <= 32'h00000000;
        end else begin
            if (wrASec) begin
                almSeconds <= mASec[`RTC_SEC_MSB:0];
            end
            if (wrAHm) begin
                almMinutes <= mAHm[`RTC_MIN_MSB:0];
                almHours   <= mAHm[`RTC_HOURS_MSB:`RTC_HOURS_LSB];
            end
            if (wrADay) begin
                almDays <= mADay[15:0];
            end
            if (wrIen) begin
                irqEnable <= mIen[`RTC_NUM_EVENTS-1:0];
            end
            status <= next_status;
            if (wrSw) begin
                stopwatch <= mSw[5:0];
            end else if (swEvt) begin
                stopwatch <= `RTC_STOPWATCH_OFF;
            end else if (minEvt && swRunning) begin
                stopwatch <= stopwatch - 6'h01;
            end
            if (wrOscU) begin
                oscUpper <= mOscU;
            end
            if (wrOscL) begin
                oscLower <= mOscL;
            end
        end
    end

    // The enable bit sits outside the soft reset on purpose.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clockEnable <= `RTC_EN_RESET;
        end else if (wrCtrl) begin
            clockEnable <= mCtrl[`RTC_CTRL_EN_BIT];
        end
    end

    // The divider rests at zero while the clock is off.
    // Match history survives a soft reset, so zeroed time and alarm raise the alarm event unless already matching.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt    <= 32'h00000000;
            sampCnt   <= 3'h0;
            matchPrev <= 1'b0;
        end else begin
            matchPrev <= match;
            if (softReset || !clockEnable || sampTick) begin
                divCnt <= 32'h00000000;
            end else begin
                divCnt <= divCnt + 32'h00000001;
            end
            if (softReset) begin
                sampCnt <= 3'h0;
            end else if (sampTick) begin
                sampCnt <= sampCnt + 3'h1;
            end
        end
    end

    // ========================================================================
    // Bus slave
    // ========================================================================
    // Unmapped words, the hole too, answer SLVERR and zero.
    wire [11:0] ra = bus.araddr;
    wire rdTake = bus.arvalid && !rvalid;
    logic [31:0] rdMux;
    logic        rdHit;
    always_comb begin
        rdHit = 1'b1;
        case (ra)
            `RTC_OFS_TIME_HM:   rdMux = curHm;
            `RTC_OFS_TIME_SEC:  rdMux = curSec;
            `RTC_OFS_ALM_HM:    rdMux = curAHm;
            `RTC_OFS_ALM_SEC:   rdMux = curASec;
            `RTC_OFS_CTRL:      rdMux = curCtrl;
            `RTC_OFS_STATUS:    rdMux = curStat;
            `RTC_OFS_IRQ_EN:    rdMux = curIen;
            `RTC_OFS_STOPWATCH: rdMux = curSw;
            `RTC_OFS_DAYS:      rdMux = curDays;
            `RTC_OFS_ALM_DAY:   rdMux = curADay;
            `RTC_OFS_OSC_UPPER: rdMux = oscUpper;
            `RTC_OFS_OSC_LOWER: rdMux = oscLower;
            default: begin
                rdMux = 32'h00000000;
                rdHit = 1'b0;
            end
        endcase
    end

    // A response stands until the master takes it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= `RTC_RESP_OKAY;
        end else if (wrTake) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
        end else if (bus.bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read data is latched at the take and then held.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `RTC_RESP_OKAY;
        end else if (rdTake) begin
            rvalid <= 1'b1;
            rdata  <= rdMux;
            rresp  <= rdHit ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
        end else if (bus.rready) begin
            rvalid <= 1'b0;
        end
    end

    // Ready rises only with both write beats present.
    assign rsp.awready = wrTake;
    assign rsp.wready  = wrTake;
    assign rsp.bvalid  = bvalid;
    assign rsp.bresp   = bresp;
    assign rsp.arready = !rvalid;
    assign rsp.rvalid  = rvalid;
    assign rsp.rdata   = rdata;
    assign rsp.rresp   = rresp;

endmodule : rtc_time_of_day_alarm
`default_nettype wire

/* rtc_time_of_day_alarm_assertions.sv */
// Concurrent checks on the clock block's bus and interrupt ports.
`timescale 1ns/1ps
`default_nettype none
module rtc_time_of_day_alarm_assertions #(
    parameter int unsigned SAMPLE_DIV = 8
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire rtc_pkg::axiReq_t bus,
    input wire rtc_pkg::axiRsp_t rsp,
    input wire logic             tick1Hz,
    input wire logic             irq
);
    import rtc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // Register bus
    a_write_answer:
        assert property (bus.awvalid && bus.wvalid && !rsp.bvalid |=> rsp.bvalid)
        else $error("Write not answered in one cycle.");
    a_bresp_holds:
        assert property (rsp.bvalid && !bus.bready |=> rsp.bvalid && $stable(rsp.bresp))
        else $error("Write response dropped before bready.");
    a_bvalid_cause:
        assert property ($rose(rsp.bvalid) |-> $past(bus.awvalid && bus.wvalid))
        else $error("Write response without a write.");
    a_read_answer:
        assert property (bus.arvalid && rsp.arready |=> rsp.rvalid)
        else $error("Read not answered in one cycle.");
    a_rdata_holds:
        assert property (rsp.rvalid && !bus.rready |=> rsp.rvalid && $stable(rsp.rdata))
        else $error("Read data changed before rready.");
    a_one_read:
        assert property (rsp.rvalid |-> !rsp.arready)
        else $error("Read accepted while one is pending.");
    a_hole_error:
        assert property (bus.arvalid && rsp.arready && bus.araddr == 12'h3F0
            |=> rsp.rresp == 2'h2 && rsp.rdata == 32'h0)
        else $error("Reserved word did not answer with an error.");
    a_hm_reserved:
        assert property (bus.arvalid && rsp.arready && bus.araddr inside {12'h3C0, 12'h3C8}
            |=> rsp.rresp == 2'h0 && rsp.rdata[31:13] == 19'h0 && rsp.rdata[7:6] == 2'h0)
        else $error("Hours-minutes word shows reserved bits.");
    a_sec_reserved:
        assert property (bus.arvalid && rsp.arready && bus.araddr inside {12'h3C4, 12'h3CC}
            |=> rsp.rresp == 2'h0 && rsp.rdata[31:6] == 26'h0)
        else $error("Seconds word shows reserved bits.");
    a_irq_after_reset:
        assert property ($fell(rst) |-> !irq)
        else $error("Interrupt high right after reset.");
    c_write_error: cover property (rsp.bvalid && rsp.bresp == 2'h2);
    c_irq_rise: cover property ($rose(irq));
    c_tick_seen: cover property (tick1Hz ##1 !tick1Hz);
endmodule : rtc_time_of_day_alarm_assertions

bind rtc_time_of_day_alarm rtc_time_of_day_alarm_assertions #(.SAMPLE_DIV(SAMPLE_DIV)) chk_inst (
    .clk     (clk),
    .rst     (rst),
    .bus     (bus),
    .rsp     (rsp),
    .tick1Hz (tick1Hz),
    .irq     (irq)
);
`default_nettype wire

/* rtc_time_of_day_alarm_tb_top.sv */
// Self-checking bench: register table, counting, events and both resets.
`timescale 1ns/1ps
`default_nettype none
module rtc_time_of_day_alarm_tb_top;
    import rtc_pkg::*;
    typedef struct {
        logic        wrFirst;
        logic [11:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic [1:0]  resp;
    } row_t;
    logic        clk;
    logic        rst;
    axiReq_t     bus;
    axiRsp_t     rsp;
    logic        tick1Hz;
    logic        irq;
    logic [31:0] rdData;
    logic [1:0]  rdResp;
    int          errCount;
    int          checkCount;
    // ==========================================================
    // Ordinary cases: reset values, then write and read back.
    row_t rows [16] = '{
        '{1'b0, 12'h3D0, 32'h0, 32'h80, 2'h0},
        '{1'b0, 12'h3DC, 32'h0, 32'h3F, 2'h0},
        '{1'b0, 12'h3E0, 32'h0, 32'h0, 2'h0},
        '{1'b0, 12'h3E4, 32'h0, 32'h0, 2'h0},
        '{1'b0, 12'h3D8, 32'h0, 32'h0, 2'h0},
        '{1'b1, 12'h3C0, 32'h173B, 32'h173B, 2'h0},
        '{1'b1, 12'h3C4, 32'h3B, 32'h3B, 2'h0},
        '{1'b1, 12'h3C8, 32'h173B, 32'h173B, 2'h0},
        '{1'b1, 12'h3CC, 32'h3B, 32'h3B, 2'h0},
        '{1'b1, 12'h3DC, 32'h25, 32'h25, 2'h0},
        '{1'b1, 12'h3E0, 32'hFFFF_FFFF, 32'hFFFF, 2'h0},
        '{1'b1, 12'h3E4, 32'hFFFF_FFFF, 32'hFFFF, 2'h0},
        '{1'b1, 12'h3F4, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 2'h0},
        '{1'b1, 12'h3F8, 32'h1234_5678, 32'h1234_5678, 2'h0},
        '{1'b1, 12'h3F0, 32'hFFFF_FFFF, 32'h0, 2'h2},
        '{1'b1, 12'h3D8, 32'h0, 32'h0, 2'h0}
    };

    // A short timer divider keeps the sampling events busy during the run.
    rtc_time_of_day_alarm #(.SAMPLE_DIV(8)) rtc_time_of_day_alarm_inst (
        .clk     (clk),
        .rst     (rst),
        .bus     (bus),
        .rsp     (rsp),
        .tick1Hz (tick1Hz),
        .irq     (irq)
    );
    always #10 clk = ~clk;

    // ==========================================================
    // Checking and bus tasks
    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check_word
    task automatic check_bit(input string nm, input logic e, input logic g);
        checkCount++;
        if (g !== e) begin
            errCount++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit
    // Each access waits one edge first so no strobe is driven twice in one step.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        @(posedge clk);
        bus.awaddr <= a;
        bus.wdata <= d;
        bus.wstrb <= s;
        bus.awvalid <= 1'b1;
        bus.wvalid <= 1'b1;
        bus.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) bus.awvalid <= 1'b0;
            if (rsp.wready) bus.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        bus.bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        bus.araddr <= a;
        bus.arvalid <= 1'b1;
        bus.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) bus.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        bus.rready <= 1'b0;
    endtask : axi_read
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        axi_write(a, d, 4'hF, rdResp);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        axi_read(a, rdData, rdResp);
        check_word($sformatf("reg %h", a), e, rdData & m);
    endtask : rdchk
    task automatic set_three(input logic alm, input logic [31:0] hm, input logic [31:0] sec,
                             input logic [31:0] day);
        wr(alm ? 12'h3C8 : 12'h3C0, hm);
        wr(alm ? 12'h3CC : 12'h3C4, sec);
        wr(alm ? 12'h3E4 : 12'h3E0, day);
    endtask : set_three
    task automatic pulse_tick();
        @(posedge clk);
        tick1Hz <= 1'b1;
        @(posedge clk);
        tick1Hz <= 1'b0;
    endtask : pulse_tick
    task automatic close_out();
        if (errCount == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        bus = '0;
        tick1Hz = 1'b0;
        errCount = 0;
        checkCount = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wrFirst) begin
                axi_write(rows[i].addr, rows[i].data, 4'hF, rdResp);
                check_word("bresp", {30'h0, rows[i].resp}, {30'h0, rdResp});
            end
            axi_read(rows[i].addr, rdData, rdResp);
            check_word("rresp", {30'h0, rows[i].resp}, {30'h0, rdResp});
            check_word($sformatf("row %0d", i), rows[i].exp, rdData);
        end
        // Only the strobed byte lane of a write lands.
        axi_write(12'h3F8, 32'hFFFF_FFFF, 4'h2, rdResp);
        rdchk(12'h3F8, 32'h1234_FF78, 32'hFFFF_FFFF);
        // Last second of a day with the stopwatch one step above zero.
        wr(12'h3D4, 32'h3FF);
        set_three(1'b0, 32'h173B, 32'h3B, 32'h5);
        wr(12'h3DC, 32'h1);
        wr(12'h3D8, 32'h8);
        check_bit("irq idle", 1'b0, irq);
        pulse_tick();
        rdchk(12'h3C4, 32'h0, 32'hFFFF_FFFF);
        rdchk(12'h3C0, 32'h0, 32'hFFFF_FFFF);
        rdchk(12'h3E0, 32'h6, 32'hFFFF_FFFF);
        rdchk(12'h3DC, 32'h0, 32'hFFFF_FFFF);
        rdchk(12'h3D4, 32'h3A, 32'h3F);
        check_bit("irq day", 1'b1, irq);
        wr(12'h3D4, 32'h8);
        check_bit("irq cleared", 1'b0, irq);
        rdchk(12'h3D4, 32'h32, 32'h3F);
        repeat (70) @(posedge clk);
        rdchk(12'h3D4, 32'h3C0, 32'h3C0);
        wr(12'h3C4, 32'h3B);
        pulse_tick();
        rdchk(12'h3D4, 32'h1, 32'h1);
        rdchk(12'h3DC, 32'h3F, 32'hFFFF_FFFF);
        // Alarm one second ahead of the running time.
        wr(12'h3D4, 32'h3FF);
        wr(12'h3D8, 32'h4);
        set_three(1'b0, 32'h0102, 32'h0A, 32'h3);
        set_three(1'b1, 32'h0102, 32'h0B, 32'h3);
        check_bit("irq early", 1'b0, irq);
        pulse_tick();
        rdchk(12'h3C4, 32'h0B, 32'hFFFF_FFFF);
        check_bit("irq alarm", 1'b1, irq);
        rdchk(12'h3D4, 32'h4, 32'h4);
        // Soft reset keeps the enable, then the enable stops counting.
        wr(12'h3D0, 32'h81);
        rdchk(12'h3D0, 32'h80, 32'hFFFF_FFFF);
        rdchk(12'h3C0, 32'h0, 32'hFFFF_FFFF);
        rdchk(12'h3DC, 32'h3F, 32'hFFFF_FFFF);
        rdchk(12'h3D8, 32'h0, 32'hFFFF_FFFF);
        check_bit("irq soft", 1'b0, irq);
        wr(12'h3D0, 32'h0);
        pulse_tick();
        rdchk(12'h3C4, 32'h0, 32'hFFFF_FFFF);
        wr(12'h3D0, 32'h80);
        pulse_tick();
        rdchk(12'h3C4, 32'h1, 32'hFFFF_FFFF);
        // Hard reset in mid-run.
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(12'h3D0, 32'h80, 32'hFFFF_FFFF);
        rdchk(12'h3C4, 32'h0, 32'hFFFF_FFC0);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        close_out();
    end
endmodule : rtc_time_of_day_alarm_tb_top
`default_nettype wire
